// >>> rtl/osc_stab_pkg.sv
package osc_stab_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 8;  // Byte address width
  localparam int DATA_W = 8;  // Register data width

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_PROC_CLK    = 8'h00;  // processor_clock_ctrl
  localparam logic [ADDR_W-1:0] OFF_MAIN_OSC    = 8'h04;  // Main oscillator control
  localparam logic [ADDR_W-1:0] OFF_STAB_SEL    = 8'h08;  // stabilization_select
  localparam logic [ADDR_W-1:0] OFF_STAB_STATUS = 8'h0C;  // stabilization_status
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS  = 8'h10;  // Sticky event bits
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK    = 8'h14;  // Event enables

  // ****************************************
  // Field positions
  // ****************************************
  localparam int POS_MAIN_CLOCK_CUT = 7;  // In processor_clock_ctrl
  localparam int POS_CPU_ON_SUB     = 4;  // In processor_clock_ctrl
  localparam int POS_MAIN_OSC_HALT  = 7;  // In main oscillator control
  localparam int SEL_W              = 3;  // stabilization_select width
  localparam int IRQ_W              = 2;  // Event bit count
  localparam int IRQ_STAB_DONE      = 0;  // Wait finished
  localparam int IRQ_STOPPED        = 1;  // STOP entered

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [SEL_W-1:0] RST_STAB_SEL = 3'h4;  // Longest wait
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 2'h0;  // All masked

  // ****************************************
  // Timing: threshold k is 2**(FIRST_EXP+k) clocks
  // ****************************************
  localparam int STAB_FIRST_EXP = 11;  // Shortest threshold exponent
  localparam int STAB_STEPS     = 5;   // Number of thresholds

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;   // Byte address
    logic [DATA_W-1:0] wdata;  // Write data
    logic              wr;     // Write strobe
    logic              rd;     // Read strobe
  } bus_req_s;

  typedef enum {
    CLK_ACTIVE,       // CPU clock running
    CLK_STOPPED,      // STOP mode, oscillator off
    CLK_STABILIZING   // Waiting for oscillator to settle
  } clk_state_e;

endpackage

// >>> rtl/stab_counter.sv
`timescale 1ns/1ps
module stab_counter
  import osc_stab_pkg::*;
#(
  parameter int FIRST_EXP = STAB_FIRST_EXP,
  parameter int STEPS     = STAB_STEPS
)(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              restart,   // Clear and relatch limit
  input  wire logic              run,       // Oscillator is oscillating
  input  wire logic [SEL_W-1:0]  limitSel,  // Requested last threshold
  output logic      [STEPS-1:0]  status,    // Bit 0 is shortest
  output logic                   done       // Selected threshold reached
);
  localparam int CNT_W = FIRST_EXP + STEPS;

  // Shift-derived threshold in clock cycles
  function automatic logic [CNT_W-1:0] thresholdOf(input int k);
    thresholdOf = CNT_W'(1) << (FIRST_EXP + k);
  endfunction

  logic [CNT_W-1:0] count;      // Cycles since oscillation began
  logic [SEL_W-1:0] limitHeld;  // Limit frozen for this wait
  logic [SEL_W-1:0] clampSel;   // Out-of-range select clamped
  logic [CNT_W-1:0] limitCount; // Cycle count of the limit
  logic [STEPS-1:0] next_status;

  assign clampSel   = (int'(limitSel) >= STEPS) ? SEL_W'(STEPS - 1) : limitSel;
  assign limitCount = thresholdOf(int'(limitHeld));
  assign done       = status[limitHeld];

  // Limit latched while restarting so mid-wait writes cannot move it
  always_ff @(posedge clk)
  begin
    if (reset)
      limitHeld <= SEL_W'(STEPS - 1);
    else if (restart)
      limitHeld <= clampSel;
  end

  // Counting frozen until oscillation and stopped at the limit
  always_ff @(posedge clk)
  begin
    if (reset || restart)
      count <= '0;
    else if (run && count < limitCount)
      count <= count + CNT_W'(1);
  end

  // Each bit sets once its threshold passes, only up to the limit
  for (genvar k = 0; k < STEPS; k++)
  begin : g_bit
    assign next_status[k] = status[k] |
        ((k <= int'(limitHeld)) && (count >= thresholdOf(k)));
  end

  always_ff @(posedge clk)
  begin
    if (reset || restart)
      status <= '0;
    else
      status <= next_status;
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_sticky;
    @(posedge clk) disable iff (reset) !restart |=> (($past(status) & ~status) == '0);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit fell");

  property p_in_order;
    @(posedge clk) disable iff (reset) ((status + STEPS'(1)) & status) == '0;
  endproperty
  a_in_order: assert property (p_in_order) else $error("status out of order");

  property p_limit;
    @(posedge clk) disable iff (reset)
      (int'(limitHeld) >= STEPS - 1) || ((status >> (int'(limitHeld) + 1)) == '0);
  endproperty
  a_limit: assert property (p_limit) else $error("bit beyond limit set");

  property p_frozen;
    @(posedge clk) disable iff (reset) (!run && !restart) |=> count == $past(count);
  endproperty
  a_frozen: assert property (p_frozen) else $error("counted before oscillation");

  property p_restart;
    @(posedge clk) disable iff (reset) restart |=> (status == '0 && count == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear");

endmodule // stab_counter

// >>> rtl/oscillation_stabilization_control.sv
`timescale 1ns/1ps
module oscillation_stabilization_control
  import osc_stab_pkg::*;
#(
  parameter int FIRST_EXP = STAB_FIRST_EXP,  // Shortest threshold exponent
  parameter int STEPS     = STAB_STEPS       // Threshold count
)(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire osc_stab_pkg::bus_req_s     busReq,         // Register request
  output logic [osc_stab_pkg::DATA_W-1:0] rdata,          // Read data, next cycle
  input  wire logic                       stopReq,        // STOP instruction pulse
  input  wire logic                       wakeReq,        // Release interrupt
  input  wire logic                       oscStartedPin,  // Oscillator alive, async
  output logic                            oscEnable,      // Main oscillator run
  output logic                            cpuClockHold,   // CPU clock gated off
  output logic                            irq             // Level interrupt
);
  import osc_stab_pkg::*;

  // ****************************************
  // Parameter checks
  // ****************************************
  if (STEPS < 1 || STEPS > DATA_W || STEPS > (1 << SEL_W))
  begin : g_bad_steps
    $error("STEPS out of range");
  end
  if (FIRST_EXP < 1 || FIRST_EXP > 24)
  begin : g_bad_exp
    $error("FIRST_EXP out of range");
  end

  // ****************************************
  // Declarations
  // ****************************************
  clk_state_e       state;         // Clock control state
  clk_state_e       next_state;    // Its next value
  logic             mainClockCut;  // Halt while on subsystem clock
  logic             cpuOnSub;      // CPU runs from subsystem clock
  logic             mainOscHalt;   // Halt while on main clock
  logic [SEL_W-1:0] stabSel;       // Selected wait threshold
  logic [IRQ_W-1:0] irqStatus;     // Sticky events
  logic [IRQ_W-1:0] irqMask;       // Event enables
  logic             oscSyncA;      // First synchroniser stage
  logic             oscSyncB;      // Safe oscillation level
  logic [STEPS-1:0] stabStatus;    // Threshold bits from counter
  logic             stabDone;      // Selected threshold reached
  logic             next_oscEnable;
  logic [IRQ_W-1:0] irqEvents;     // Event pulses this cycle
  logic [IRQ_W-1:0] next_irqStatus;
  logic [DATA_W-1:0] readMux;      // Selected read value

  // ****************************************
  // Address decode
  // ****************************************
  wire hitProcClk  = busReq.addr == OFF_PROC_CLK;
  wire hitMainOsc  = busReq.addr == OFF_MAIN_OSC;
  wire hitStabSel  = busReq.addr == OFF_STAB_SEL;
  wire hitStatus   = busReq.addr == OFF_STAB_STATUS;
  wire hitIrqStat  = busReq.addr == OFF_IRQ_STATUS;
  wire hitIrqMask  = busReq.addr == OFF_IRQ_MASK;
  wire wrProcClk   = busReq.wr && hitProcClk;
  wire wrMainOsc   = busReq.wr && hitMainOsc;
  wire wrStabSel   = busReq.wr && hitStabSel;
  wire wrIrqStat   = busReq.wr && hitIrqStat;
  wire wrIrqMask   = busReq.wr && hitIrqMask;

  // ****************************************
  // Control registers
  // ****************************************
  // Clock control bits; status register is read-only
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mainClockCut <= 1'b0;
      cpuOnSub     <= 1'b0;
    end
    else if (wrProcClk)
    begin
      mainClockCut <= busReq.wdata[POS_MAIN_CLOCK_CUT];
      cpuOnSub     <= busReq.wdata[POS_CPU_ON_SUB];
    end
  end

  // Main oscillator halt, honoured only on main clock
  always_ff @(posedge clk)
  begin
    if (reset)
      mainOscHalt <= 1'b0;
    else if (wrMainOsc)
      mainOscHalt <= busReq.wdata[POS_MAIN_OSC_HALT];
  end

  // Select; relatched throughout STOP, so the value held at wake sets the limit
  always_ff @(posedge clk)
  begin
    if (reset)
      stabSel <= RST_STAB_SEL;
    else if (wrStabSel)
      stabSel <= busReq.wdata[SEL_W-1:0];
  end

  // Interrupt enables
  always_ff @(posedge clk)
  begin
    if (reset)
      irqMask <= RST_IRQ_MASK;
    else if (wrIrqMask)
      irqMask <= busReq.wdata[IRQ_W-1:0];
  end

  // ****************************************
  // Oscillator-alive synchroniser
  // ****************************************
  // Pin comes from the analog oscillator, not from clk
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      oscSyncA <= 1'b0;
      oscSyncB <= 1'b0;
    end
    else
    begin
      oscSyncA <= oscStartedPin;
      oscSyncB <= oscSyncA;
    end
  end

  // ****************************************
  // Stabilization counter
  // ****************************************
  // Restart held throughout STOP so the limit tracks the latest select
  wire counterRestart = (state == CLK_STOPPED) ||
                        (state == CLK_ACTIVE && stopReq);
  wire counterRun     = (state == CLK_STABILIZING) && oscSyncB;

  stab_counter #(
    .FIRST_EXP (FIRST_EXP),
    .STEPS     (STEPS)
  ) u_counter (
    .clk      (clk),
    .reset    (reset),
    .restart  (counterRestart),
    .run      (counterRun),
    .limitSel (stabSel),
    .status   (stabStatus),
    .done     (stabDone)
  );

  // ****************************************
  // Clock control state machine
  // ****************************************
  // Reset starts in the wait, so a cold start also settles first
  always_comb
  begin
    next_state = state;
    unique case (state)
      CLK_ACTIVE:
        if (stopReq)
          next_state = CLK_STOPPED;
      CLK_STOPPED:
        if (wakeReq)
          next_state = CLK_STABILIZING;
      CLK_STABILIZING:
        if (stabDone)
          next_state = CLK_ACTIVE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state <= CLK_STABILIZING;
    else
      state <= next_state;
  end

  // ****************************************
  // Oscillator enable
  // ****************************************
  // On subsystem clock the halt bit is ignored; only the cut bit counts
  wire runHalt = cpuOnSub ? mainClockCut : mainOscHalt;
  always_comb
  begin
    unique case (next_state)
      CLK_STOPPED:     next_oscEnable = 1'b0;
      CLK_STABILIZING: next_oscEnable = 1'b1;
      CLK_ACTIVE:      next_oscEnable = !runHalt;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      oscEnable    <= 1'b1;
      cpuClockHold <= 1'b1;
    end
    else
    begin
      oscEnable    <= next_oscEnable;
      cpuClockHold <= next_state != CLK_ACTIVE;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  // Set beats a same-cycle write-one-to-clear, so no event is lost
  assign irqEvents[IRQ_STAB_DONE] = (state == CLK_STABILIZING) && stabDone;
  assign irqEvents[IRQ_STOPPED]   = (state == CLK_ACTIVE) && stopReq;
  assign next_irqStatus = (irqStatus & ~(wrIrqStat ? busReq.wdata[IRQ_W-1:0] : '0))
                          | irqEvents;
  // Mask written this cycle already counts, so irq never lags the mask
  wire [IRQ_W-1:0] next_irqMask = wrIrqMask ? busReq.wdata[IRQ_W-1:0] : irqMask;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irqStatus <= '0;
      irq       <= 1'b0;
    end
    else
    begin
      irqStatus <= next_irqStatus;
      irq       <= |(next_irqStatus & next_irqMask);
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Unmapped addresses read as zero
  assign readMux =
      hitProcClk ? (DATA_W'(mainClockCut) << POS_MAIN_CLOCK_CUT) |
                   (DATA_W'(cpuOnSub) << POS_CPU_ON_SUB) :
      hitMainOsc ? DATA_W'(mainOscHalt) << POS_MAIN_OSC_HALT :
      hitStabSel ? DATA_W'(stabSel) :
      hitStatus  ? DATA_W'(stabStatus) :
      hitIrqStat ? DATA_W'(irqStatus) :
      hitIrqMask ? DATA_W'(irqMask) :
                   '0;

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata <= '0;
    else
      rdata <= busReq.rd ? readMux : '0;
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_enter_stop;
    state == CLK_ACTIVE && stopReq;
  endsequence

  property p_stop_entry;
    @(posedge clk) disable iff (reset)
      s_enter_stop |=> (state == CLK_STOPPED && !oscEnable && stabStatus == '0);
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("STOP entry wrong");

  property p_cut_on_sub;
    @(posedge clk) disable iff (reset)
      (next_state == CLK_ACTIVE && cpuOnSub && mainClockCut) |=> !oscEnable;
  endproperty
  a_cut_on_sub: assert property (p_cut_on_sub) else $error("cut ignored");

  property p_halt_ignored;
    @(posedge clk) disable iff (reset)
      (next_state == CLK_ACTIVE && cpuOnSub && !mainClockCut) |=> oscEnable;
  endproperty
  a_halt_ignored: assert property (p_halt_ignored) else $error("halt obeyed on sub");

  sequence s_wake;
    state == CLK_STOPPED && wakeReq;
  endsequence

  property p_no_early_count;
    @(posedge clk) disable iff (reset)
      s_wake ##1 (!oscSyncB && state == CLK_STABILIZING) [*2] |-> stabStatus == '0;
  endproperty
  a_no_early_count: assert property (p_no_early_count) else $error("early status");

  property p_hold_level;
    @(posedge clk) disable iff (reset) cpuClockHold == (state != CLK_ACTIVE);
  endproperty
  a_hold_level: assert property (p_hold_level) else $error("hold mismatch");

  property p_irq_level;
    @(posedge clk) disable iff (reset) irq == |(irqStatus & irqMask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

  property p_done_event;
    @(posedge clk) disable iff (reset)
      (state == CLK_STABILIZING && stabDone) |=> irqStatus[IRQ_STAB_DONE] && !cpuClockHold;
  endproperty
  a_done_event: assert property (p_done_event) else $error("done not flagged");

endmodule // oscillation_stabilization_control

// >>> bench/oscillation_stabilization_control_test.sv
`timescale 1ns/1ps
module oscillation_stabilization_control_test;
  import osc_stab_pkg::*;

  // ****************************************
  // Stimulus and observation signals
  // ****************************************
  logic              clk;           // 40 MHz bench clock
  logic              reset;         // Synchronous, active high
  bus_req_s          busReq;        // Register request
  logic [DATA_W-1:0] rdata;         // Read data, cycle after rd
  logic              stopReq;       // STOP instruction pulse
  logic              wakeReq;       // Release interrupt pulse
  logic              oscStartedPin; // Oscillator alive
  logic              oscEnable;     // Main oscillator run
  logic              cpuClockHold;  // CPU clock held
  logic              irq;           // Level interrupt
  int                failures;      // Mismatch count
  int                check_count;   // Comparison count
  int                cycles;        // Timeout counter
  logic [7:0]        v;             // Last read value
  logic [7:0]        prev;          // Previous status read
  int                g;             // Poll guard

  // Short thresholds keep the run brief: 4, 8, 16, 32, 64 cycles
  oscillation_stabilization_control #(
    .FIRST_EXP (2),
    .STEPS     (5)
  ) uut (
    .clk           (clk),
    .reset         (reset),
    .busReq        (busReq),
    .rdata         (rdata),
    .stopReq       (stopReq),
    .wakeReq       (wakeReq),
    .oscStartedPin (oscStartedPin),
    .oscEnable     (oscEnable),
    .cpuClockHold  (cpuClockHold),
    .irq           (irq)
  );

  // ****************************************
  // Clock and hang guard
  // ****************************************
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // Longest path is six wake cycles of under 600 cycles each
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failures = failures + 1;
      stop_test();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Single-cycle pulse on a control input
  task automatic pulse(input bit wake);
    @(posedge clk);
    if (wake)
      wakeReq <= 1'b1;
    else
      stopReq <= 1'b1;
    @(posedge clk);
    wakeReq <= 1'b0;
    stopReq <= 1'b0;
  endtask

  // Poll status while held; every view must be a growing run of ones
  task automatic poll_status();
    prev = 8'h00;
    g = 0;
    while (cpuClockHold !== 1'b0 && g < 300)
    begin
      rd(OFF_STAB_STATUS, v);
      chk("status form", v & (v + 8'h01), 8'h00);
      chk("status kept", v & prev, prev);
      prev = v;
      g = g + 1;
    end
    chk("hold released", {7'h00, cpuClockHold}, 8'h00);
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    failures = 0;
    check_count = 0;
    cycles = 0;
    reset = 1'b1;
    busReq = '0;
    stopReq = 1'b0;
    wakeReq = 1'b0;
    oscStartedPin = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("reset hold", {7'h00, cpuClockHold}, 8'h01);
    chk("reset osc", {7'h00, oscEnable}, 8'h01);
    chk("reset irq", {7'h00, irq}, 8'h00);
    rd(OFF_STAB_SEL, v);
    chk("sel reset", v, {5'h00, RST_STAB_SEL});
    rd(OFF_IRQ_MASK, v);
    chk("mask reset", v, {6'h00, RST_IRQ_MASK});
    // No oscillation yet: the wait must not advance
    repeat (80) @(posedge clk);
    rd(OFF_STAB_STATUS, v);
    chk("status before osc", v, 8'h00);
    @(posedge clk) oscStartedPin <= 1'b1;
    poll_status();
    rd(OFF_STAB_STATUS, v);
    chk("status after reset", v, 8'h1F);

    // Every select code, plus one beyond the range that clamps
    for (int s = 0; s < 6; s++)
    begin
      wr(OFF_STAB_SEL, 8'(s));
      pulse(1'b0);
      oscStartedPin <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("stop osc", {7'h00, oscEnable}, 8'h00);
      chk("stop hold", {7'h00, cpuClockHold}, 8'h01);
      rd(OFF_STAB_STATUS, v);
      chk("status on stop", v, 8'h00);
      pulse(1'b1);
      // Release came first; oscillator is late to start
      repeat (90) @(posedge clk);
      rd(OFF_STAB_STATUS, v);
      chk("status no osc", v, 8'h00);
      chk("still held", {7'h00, cpuClockHold}, 8'h01);
      @(posedge clk) oscStartedPin <= 1'b1;
      poll_status();
      repeat (150) @(posedge clk);
      rd(OFF_STAB_STATUS, v);
      chk("status limit", v, (8'h02 << (s > 4 ? 4 : s)) - 8'h01);
    end

    // Read-only status and unmapped place
    wr(OFF_STAB_STATUS, 8'h00);
    rd(OFF_STAB_STATUS, v);
    chk("status ro", v, 8'h1F);
    rd(8'h20, v);
    chk("unmapped", v, 8'h00);

    // Oscillator halt paths while on the subsystem clock and off it
    wr(OFF_PROC_CLK, 8'h10);
    wr(OFF_MAIN_OSC, 8'h80);
    repeat (3) @(posedge clk);
    #1 chk("halt ignored on sub", {7'h00, oscEnable}, 8'h01);
    wr(OFF_PROC_CLK, 8'h90);
    repeat (3) @(posedge clk);
    #1 chk("cut on sub", {7'h00, oscEnable}, 8'h00);
    wr(OFF_PROC_CLK, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk("halt on main", {7'h00, oscEnable}, 8'h00);
    wr(OFF_MAIN_OSC, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk("osc back", {7'h00, oscEnable}, 8'h01);

    // Interrupt: both events are pending, mask then clear
    rd(OFF_IRQ_STATUS, v);
    chk("irq status", v, 8'h03);
    chk("irq masked", {7'h00, irq}, 8'h00);
    wr(OFF_IRQ_MASK, 8'h02);
    repeat (2) @(posedge clk);
    #1 chk("irq raised", {7'h00, irq}, 8'h01);
    wr(OFF_IRQ_STATUS, 8'h02);
    repeat (2) @(posedge clk);
    #1 chk("irq cleared", {7'h00, irq}, 8'h00);
    rd(OFF_IRQ_STATUS, v);
    chk("irq left", v, 8'h01);
    wr(OFF_IRQ_STATUS, 8'h01);
    rd(OFF_IRQ_STATUS, v);
    chk("irq empty", v, 8'h00);
    stop_test();
  end

endmodule // oscillation_stabilization_control_test
